// *** gpio_cfg_defs.svh ***
/*
  Constants for the GPIO pin configuration and bank data block: register indices, reset values,
  field positions and masks. Assumes it is included once per compilation unit by bare name.
*/
// Functional notes
// RULE_01: Bit 0 of each pin configuration register sets direction, 1 input and 0 output.
// RULE_02: Bit 1 of each pin configuration register inverts the pin value when set.
// RULE_03: Bit 7 of each pin configuration register selects open-drain when set, else push-pull.
// RULE_04: For pins 5.6 and 5.7 bit 2 selects clear-to-send in and terminal-ready out of port 2.
// RULE_05: For pin 6.0 bits 3:2 select 10 edge interrupt 4, 01 first LED, 00 GPIO.
// RULE_06: For pin 6.1 bits 3:2 select 10 edge interrupt 5, 01 second LED, 00 GPIO; reset 0x04.
// RULE_07: For pin 6.2 bits 3:2 select 10 IRQ input C, 01 keyboard port 1 bit 7, 00 GPIO.
// RULE_08: Bank 1 data register at 4B maps bits 0 to 7 onto pins 1.0 to 1.7.
// RULE_09: Bank 2 data register at 4C maps bits 0 to 7 onto pins 2.0 to 2.7.
// RULE_10: Bank 3 data register at 4D maps pins 3.0 to 3.7; bit 3 also clears on main or hard reset.
// RULE_11: Bank 4 data register at 4E maps bits 0 to 3 onto pins 4.0 to 4.3; bits 7:4 reserved.
// RULE_12: Data bits read the adjusted pad level for inputs and drive the adjusted value for outputs.
`ifndef GPIO_CFG_DEFS_SVH
`define GPIO_CFG_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_PIN56 8'h45
`define IDX_PIN57 8'h46
`define IDX_PIN60 8'h47
`define IDX_PIN61 8'h48
`define IDX_PIN62 8'h49
`define IDX_BANK1 8'h4b
`define IDX_BANK2 8'h4c
`define IDX_BANK3 8'h4d
`define IDX_BANK4 8'h4e
`define IDX_NONE 8'h00
`define ADDR_IDX_HI 9
`define ADDR_IDX_LO 2
`define ADDR_TOP 31
`define ADDR_UPPER_LO 10
`define HSIZE_WORD 3'h2

// ----------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------
`define RST_PIN_CFG 8'h01
`define RST_PIN61_CFG 8'h04
`define CFG_DIR 0
`define CFG_INV 1
`define CFG_ALT 2
`define CFG_FN_HI 3
`define CFG_FN_LO 2
`define CFG_OD 7
`define MASK_CFG_ALT1 8'h87
`define MASK_CFG_ALT2 8'h8f
`define FN_GPIO 2'h0
`define FN_OUTSIDE 2'h1
`define FN_INSIDE 2'h2
`define BANK_W 8
`define BANK4_W 4
`define BANK1_LSB 0
`define BANK2_LSB 8
`define BANK3_LSB 16
`define BANK4_LSB 24
`define BANK3_MAIN_CLR_BIT 19
`define SLOT_P56 0
`define SLOT_P57 1
`define SLOT_P60 2
`define SLOT_P61 3
`define SLOT_P62 4

`endif

// *** gpio_cfg_pkg.sv ***
/*
  Types shared by the GPIO configuration block: bus states and register selects.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package gpio_cfg_pkg;
  typedef enum logic [1:0] {BUS_IDLE = 2'b00, BUS_WRITE = 2'b01, BUS_READ = 2'b11} bus_state_t;
  typedef enum logic [3:0] {
    SEL_P56 = 4'h0, SEL_P57 = 4'h1, SEL_P60 = 4'h2, SEL_P61 = 4'h3, SEL_P62 = 4'h4,
    SEL_B1 = 4'h5, SEL_B2 = 4'h6, SEL_B3 = 4'h7, SEL_B4 = 4'h8, SEL_NONE = 4'hf
  } reg_sel_t;
endpackage
`default_nettype wire

// *** gpio_pad_bank.sv ***
/*
  A group of pad cells: synchronises pad inputs, applies polarity and forms the drive.
  Assumes control inputs come from logic on sys_clk and pad inputs from outside it.
*/
`default_nettype none
module gpio_pad_bank #(
  parameter int N = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  // Per-pin control
  input wire logic [N-1:0] dirIn,
  input wire logic [N-1:0] invert,
  input wire logic [N-1:0] openDrain,
  input wire logic [N-1:0] value,
  // Pads
  input wire logic [N-1:0] padIn,
  output logic [N-1:0] padOut,
  output logic [N-1:0] padOeN,
  // Adjusted level
  output logic [N-1:0] level
);
  if (N < 1)
  begin : g_bad
    $error("gpio_pad_bank needs at least one pin");
  end

  logic [N-1:0] sync1_reg;
  logic [N-1:0] sync2_reg;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      level <= '0;
    end
    else if (ce)
    begin
      sync1_reg <= padIn;
      sync2_reg <= sync1_reg;
      level <= sync2_reg ^ invert; // RULE_02
    end
  end

  // Open-drain only pulls low, so its enable follows the data and the data line stays low.
  for (genvar i = 0; i < N; i++)
  begin : g_pin
    always_ff @(posedge sys_clk or negedge nrst)
    begin
      if (!nrst)
      begin
        padOut[i] <= 1'b0;
        padOeN[i] <= 1'b1;
      end
      else if (ce)
      begin
        if (dirIn[i]) // RULE_01
        begin
          padOut[i] <= 1'b0;
          padOeN[i] <= 1'b1;
        end
        else if (openDrain[i]) // RULE_03
        begin
          padOut[i] <= 1'b0;
          padOeN[i] <= value[i] ^ invert[i];
        end
        else
        begin
          padOut[i] <= value[i] ^ invert[i]; // RULE_12
          padOeN[i] <= 1'b0;
        end
      end
    end
  end
endmodule // gpio_pad_bank
`default_nettype wire

// *** edge_event.sv ***
/*
  Either-edge event detectors with per-channel enable, one pulse per level change.
  Assumes the levels are already synchronous to sys_clk.
*/
`default_nettype none
module edge_event #(
  parameter int N = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  // Levels in, pulses out
  input wire logic [N-1:0] enable,
  input wire logic [N-1:0] level,
  output logic [N-1:0] pulse
);
  if (N < 1)
  begin : g_bad
    $error("edge_event needs at least one channel");
  end

  logic [N-1:0] prev_reg;

  // The previous level is tracked even while disabled, so enabling gives no false edge.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prev_reg <= '0;
      pulse <= '0;
    end
    else if (ce)
    begin
      prev_reg <= level;
      pulse <= enable & (level ^ prev_reg);
    end
  end
endmodule // edge_event
`default_nettype wire

// *** gpio_pin_config_and_data.sv ***
/*
  GPIO pin configuration registers for pins 5.6 to 6.2 and data registers for banks 1 to 4,
  reached as an AHB-Lite slave. Assumes bank pin direction, polarity and drive type come from
  configuration logic on sys_clk, and that nrst is the standby power-on reset.
*/
`default_nettype none
`include "gpio_cfg_defs.svh"
module gpio_pin_config_and_data #(
  parameter int BANK_PINS = 28,
  parameter int CFG_PINS = 5
) (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  // Other resets, asynchronous pins, active high
  input wire logic mainPowerRst,
  input wire logic hardRst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Bank 1 to 4 pads and their configuration
  input wire logic [27:0] bankPadIn,
  output logic [27:0] bankPadOut,
  output logic [27:0] bankPadOeN,
  input wire logic [27:0] bankDir,
  input wire logic [27:0] bankInvert,
  input wire logic [27:0] bankOpenDrain,
  // Configured pads 5.6, 5.7, 6.0, 6.1, 6.2 and their GPIO data path
  input wire logic [4:0] cfgPadIn,
  output logic [4:0] cfgPadOut,
  output logic [4:0] cfgPadOeN,
  input wire logic [4:0] extData,
  output logic [4:0] extLevel,
  // Alternate functions
  input wire logic serial2TerminalReadyOut,
  input wire logic ledDriveFirst,
  input wire logic ledDriveSecond,
  output logic serial2ClearToSendIn,
  output logic irqRequestInputC,
  output logic kbcPort1Bit7,
  output logic [1:0] edgeIrq
);
  import gpio_cfg_pkg::*;

  if (BANK_PINS != 28 || CFG_PINS != 5)
  begin : g_bad
    $error("pin counts are fixed by the register map");
  end

  // ----------------------------------------------------------------
  // Register select decode
  // ----------------------------------------------------------------
  function automatic reg_sel_t decodeSel(input logic [7:0] idx);
    reg_sel_t s;
    s = SEL_NONE;
    if (idx == `IDX_PIN56) s = SEL_P56;
    else if (idx == `IDX_PIN57) s = SEL_P57;
    else if (idx == `IDX_PIN60) s = SEL_P60;
    else if (idx == `IDX_PIN61) s = SEL_P61;
    else if (idx == `IDX_PIN62) s = SEL_P62;
    else if (idx == `IDX_BANK1) s = SEL_B1; // RULE_08
    else if (idx == `IDX_BANK2) s = SEL_B2; // RULE_09
    else if (idx == `IDX_BANK3) s = SEL_B3; // RULE_10
    else if (idx == `IDX_BANK4) s = SEL_B4; // RULE_11
    return s;
  endfunction

  function automatic logic [7:0] cfgMask(input int slot);
    return (slot <= `SLOT_P57) ? `MASK_CFG_ALT1 : `MASK_CFG_ALT2;
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  bus_state_t busState_reg;
  logic [7:0] addrIdx_reg;
  logic hrespZero_reg;
  logic xferStart;
  logic [7:0] readValue;
  reg_sel_t curSel;

  assign xferStart = hsel & htrans[1] & hready;
  assign curSel = decodeSel(addrIdx_reg);
  assign hresp = hrespZero_reg;

  // Reads take one wait state so that hrdata leaves a flip-flop; writes complete at once.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busState_reg <= BUS_IDLE;
      addrIdx_reg <= `IDX_NONE;
      hreadyout <= 1'b1;
      hrdata <= '0;
      hrespZero_reg <= 1'b0;
    end
    else if (ce)
    begin
      case (busState_reg)
        BUS_READ:
        begin
          hrdata <= {24'h000000, readValue};
          hreadyout <= 1'b1;
          busState_reg <= BUS_IDLE;
        end
        default:
        begin
          if (xferStart)
          begin
            // Non-word or out-of-range accesses fall on no register: read zero, write ignored.
            if (~|haddr[`ADDR_TOP:`ADDR_UPPER_LO] && hsize == `HSIZE_WORD)
              addrIdx_reg <= haddr[`ADDR_IDX_HI:`ADDR_IDX_LO];
            else
              addrIdx_reg <= `IDX_NONE;
            if (hwrite)
              busState_reg <= BUS_WRITE;
            else
            begin
              busState_reg <= BUS_READ;
              hreadyout <= 1'b0;
            end
          end
          else
            busState_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Other reset synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rstSync1_reg;
  logic [1:0] rstSync2_reg;
  logic mainClear;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstSync1_reg <= '0;
      rstSync2_reg <= '0;
    end
    else if (ce)
    begin
      rstSync1_reg <= {hardRst, mainPowerRst};
      rstSync2_reg <= rstSync1_reg;
    end
  end

  assign mainClear = |rstSync2_reg;

  // ----------------------------------------------------------------
  // Pin configuration registers
  // ----------------------------------------------------------------
  logic [7:0] cfgReg [0:4];
  logic busWrite;

  assign busWrite = (busState_reg == BUS_WRITE);

  for (genvar i = 0; i < 5; i++)
  begin : g_cfg
    always_ff @(posedge sys_clk or negedge nrst)
    begin
      if (!nrst)
        cfgReg[i] <= (i == `SLOT_P61) ? `RST_PIN61_CFG : `RST_PIN_CFG; // RULE_06
      else if (ce && busWrite && curSel == reg_sel_t'(i))
        cfgReg[i] <= hwdata[7:0] & cfgMask(i); // RULE_04
    end
  end

  // ----------------------------------------------------------------
  // Bank data registers
  // ----------------------------------------------------------------
  logic [27:0] bankOut_reg;
  logic [27:0] bankLevel;
  logic [27:0] bankRead;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      bankOut_reg <= '0;
    else if (ce)
    begin
      if (busWrite)
      begin
        case (curSel)
          SEL_B1: bankOut_reg[`BANK1_LSB +: `BANK_W] <= hwdata[`BANK_W-1:0]; // RULE_08
          SEL_B2: bankOut_reg[`BANK2_LSB +: `BANK_W] <= hwdata[`BANK_W-1:0]; // RULE_09
          SEL_B3: bankOut_reg[`BANK3_LSB +: `BANK_W] <= hwdata[`BANK_W-1:0]; // RULE_10
          SEL_B4: bankOut_reg[`BANK4_LSB +: `BANK4_W] <= hwdata[`BANK4_W-1:0]; // RULE_11
          default: ;
        endcase
      end
      // The main-power and hard resets clear only this bit and take priority over a write.
      if (mainClear)
        bankOut_reg[`BANK3_MAIN_CLR_BIT] <= 1'b0; // RULE_10
    end
  end

  // Inputs read the pad, outputs read back what software last wrote.
  assign bankRead = (bankDir & bankLevel) | (~bankDir & bankOut_reg); // RULE_12

  always_comb
  begin
    readValue = '0;
    case (curSel)
      SEL_P56: readValue = cfgReg[`SLOT_P56];
      SEL_P57: readValue = cfgReg[`SLOT_P57];
      SEL_P60: readValue = cfgReg[`SLOT_P60];
      SEL_P61: readValue = cfgReg[`SLOT_P61];
      SEL_P62: readValue = cfgReg[`SLOT_P62];
      SEL_B1: readValue = bankRead[`BANK1_LSB +: `BANK_W];
      SEL_B2: readValue = bankRead[`BANK2_LSB +: `BANK_W];
      SEL_B3: readValue = bankRead[`BANK3_LSB +: `BANK_W];
      SEL_B4: readValue = {4'h0, bankRead[`BANK4_LSB +: `BANK4_W]}; // RULE_11
      default: readValue = '0;
    endcase
  end

  gpio_pad_bank #(
    .N(28)
  ) u_bank_pads (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .dirIn(bankDir),
    .invert(bankInvert),
    .openDrain(bankOpenDrain),
    .value(bankOut_reg),
    .padIn(bankPadIn),
    .padOut(bankPadOut),
    .padOeN(bankPadOeN),
    .level(bankLevel)
  );

  // ----------------------------------------------------------------
  // Configured pin functions
  // ----------------------------------------------------------------
  logic [4:0] cfgDir;
  logic [4:0] cfgInv;
  logic [4:0] cfgOd;
  logic [4:0] cfgValue;
  logic [1:0] fn60;
  logic [1:0] fn61;
  logic [1:0] fn62;
  logic alt56;
  logic alt57;

  assign alt56 = cfgReg[`SLOT_P56][`CFG_ALT];
  assign alt57 = cfgReg[`SLOT_P57][`CFG_ALT];
  assign fn60 = cfgReg[`SLOT_P60][`CFG_FN_HI:`CFG_FN_LO];
  assign fn61 = cfgReg[`SLOT_P61][`CFG_FN_HI:`CFG_FN_LO];
  assign fn62 = cfgReg[`SLOT_P62][`CFG_FN_HI:`CFG_FN_LO];

  for (genvar i = 0; i < 5; i++)
  begin : g_attr
    assign cfgInv[i] = cfgReg[i][`CFG_INV]; // RULE_02
    assign cfgOd[i] = cfgReg[i][`CFG_OD]; // RULE_03
  end

  // Input functions force the pad to input; output functions force it to drive.
  always_comb
  begin
    cfgValue = extData;
    cfgDir[`SLOT_P56] = alt56 | cfgReg[`SLOT_P56][`CFG_DIR]; // RULE_04
    cfgDir[`SLOT_P57] = ~alt57 & cfgReg[`SLOT_P57][`CFG_DIR]; // RULE_01
    if (alt57)
      cfgValue[`SLOT_P57] = serial2TerminalReadyOut; // RULE_04
    cfgDir[`SLOT_P60] = cfgReg[`SLOT_P60][`CFG_DIR];
    if (fn60 == `FN_INSIDE)
      cfgDir[`SLOT_P60] = 1'b1; // RULE_05
    else if (fn60 == `FN_OUTSIDE)
    begin
      cfgDir[`SLOT_P60] = 1'b0;
      cfgValue[`SLOT_P60] = ledDriveFirst; // RULE_05
    end
    cfgDir[`SLOT_P61] = cfgReg[`SLOT_P61][`CFG_DIR];
    if (fn61 == `FN_INSIDE)
      cfgDir[`SLOT_P61] = 1'b1; // RULE_06
    else if (fn61 == `FN_OUTSIDE)
    begin
      cfgDir[`SLOT_P61] = 1'b0;
      cfgValue[`SLOT_P61] = ledDriveSecond; // RULE_06
    end
    cfgDir[`SLOT_P62] = cfgReg[`SLOT_P62][`CFG_DIR];
    if (fn62 == `FN_INSIDE || fn62 == `FN_OUTSIDE)
      cfgDir[`SLOT_P62] = 1'b1; // RULE_07
  end

  gpio_pad_bank #(
    .N(5)
  ) u_cfg_pads (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .dirIn(cfgDir),
    .invert(cfgInv),
    .openDrain(cfgOd),
    .value(cfgValue),
    .padIn(cfgPadIn),
    .padOut(cfgPadOut),
    .padOeN(cfgPadOeN),
    .level(extLevel)
  );

  // Unselected inputs rest at their idle level so the consumers see no activity.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      serial2ClearToSendIn <= 1'b1;
      irqRequestInputC <= 1'b0;
      kbcPort1Bit7 <= 1'b1;
    end
    else if (ce)
    begin
      serial2ClearToSendIn <= alt56 ? extLevel[`SLOT_P56] : 1'b1; // RULE_04
      irqRequestInputC <= (fn62 == `FN_INSIDE) ? extLevel[`SLOT_P62] : 1'b0; // RULE_07
      kbcPort1Bit7 <= (fn62 == `FN_OUTSIDE) ? extLevel[`SLOT_P62] : 1'b1; // RULE_07
    end
  end

  edge_event #(
    .N(2)
  ) u_edge (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .enable({fn61 == `FN_INSIDE, fn60 == `FN_INSIDE}), // RULE_05
    .level({extLevel[`SLOT_P61], extLevel[`SLOT_P60]}),
    .pulse(edgeIrq)
  );
endmodule // gpio_pin_config_and_data
`default_nettype wire

// *** gpio_pin_config_and_data_props.sv ***
/*
  Checker for the GPIO configuration block: bus timing and bank pad drive relations.
  Assumes it is bound into the block and sees only the block's ports.
*/
`default_nettype none
module gpio_pin_config_and_data_props #(
  parameter int BANK_PINS = 28,
  parameter int CFG_PINS = 5
) (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic mainPowerRst,
  input wire logic hardRst,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pads and routed inputs
  input wire logic [27:0] bankDir,
  input wire logic [27:0] bankInvert,
  input wire logic [27:0] bankOpenDrain,
  input wire logic [27:0] bankPadOut,
  input wire logic [27:0] bankPadOeN,
  input wire logic irqRequestInputC,
  input wire logic kbcPort1Bit7
);
  logic [27:0] ppMask;
  logic [27:0] odMask;
  assign ppMask = ~bankDir & ~bankOpenDrain;
  assign odMask = ~bankDir & bankOpenDrain;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  sequence read_take;
    hsel && htrans[1] && hready && ce && !hwrite;
  endsequence
  sequence write_take;
    hsel && htrans[1] && hready && ce && hwrite;
  endsequence
  sequence read_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  read_wait_a: assert property (read_take |=> read_answer)
    else $error("read data phase was not one wait long");
  write_nowait_a: assert property (write_take |=> hreadyout)
    else $error("write data phase stalled");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response was not okay");
  input_float_a: assert property (
    ce |=> (bankPadOeN & $past(bankDir)) == $past(bankDir))
    else $error("input pin was driven");
  push_pull_a: assert property (
    ce |=> (bankPadOeN & $past(ppMask)) == 28'h0)
    else $error("push-pull output not driven");
  drain_low_a: assert property (
    ce |=> (bankPadOut & $past(odMask)) == 28'h0)
    else $error("open-drain output drove high");
  main_clear_a: assert property (
    (ce && (mainPowerRst || hardRst))[*4] |=> $past(bankDir[19]) ||
    $past(bankOpenDrain[19]) || bankPadOut[19] == $past(bankInvert[19]))
    else $error("pin 3.3 not cleared by main or hard reset");
  irq_kbc_a: assert property (irqRequestInputC |-> kbcPort1Bit7)
    else $error("irq input and keyboard bit both selected");
endmodule // gpio_pin_config_and_data_props

bind gpio_pin_config_and_data gpio_pin_config_and_data_props #(
  .BANK_PINS(BANK_PINS), .CFG_PINS(CFG_PINS)) i_props (
  .sys_clk, .nrst, .ce, .mainPowerRst, .hardRst, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .bankDir, .bankInvert, .bankOpenDrain, .bankPadOut, .bankPadOeN,
  .irqRequestInputC, .kbcPort1Bit7
);
`default_nettype wire

// *** test_gpio_pin_config_and_data.sv ***
/*
  Self-checking bench for the GPIO configuration block, driving its bus and pads directly.
  Assumes the block's own files and the checker are compiled before it.
*/
`default_nettype none
`include "gpio_cfg_defs.svh"
module test_gpio_pin_config_and_data;
  timeunit 1ns;
  timeprecision 100ps;
  import gpio_cfg_pkg::*;
  logic sys_clk = 0, nrst = 0, ce = 1, mainPowerRst = 0, hardRst = 0, hsel = 1, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0, edgeIrq;
  logic [2:0] hsize = `HSIZE_WORD;
  logic hreadyout, hresp, serial2ClearToSendIn, irqRequestInputC, kbcPort1Bit7;
  logic serial2TerminalReadyOut = 0, ledDriveFirst = 0, ledDriveSecond = 1;
  logic [27:0] bankPadIn = 0, bankPadOut, bankPadOeN, bankDir = '1, bankInvert = 0;
  logic [27:0] bankOpenDrain = 0;
  logic [4:0] cfgPadIn = 0, cfgPadOut, cfgPadOeN, extData = 0, extLevel;
  int failures = 0, n_compared = 0;
  localparam logic [7:0] IDX [9] = '{`IDX_PIN56, `IDX_PIN57, `IDX_PIN60, `IDX_PIN61,
    `IDX_PIN62, `IDX_BANK1, `IDX_BANK2, `IDX_BANK3, `IDX_BANK4};
  localparam logic [7:0] RST [5] = '{8'h01, 8'h01, 8'h01, 8'h04, 8'h01};
  localparam logic [7:0] MSK [5] = '{8'h87, 8'h87, 8'h8f, 8'h8f, 8'h8f};

  gpio_pin_config_and_data i_dut (.sys_clk, .nrst, .ce, .mainPowerRst, .hardRst, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .bankPadIn, .bankPadOut, .bankPadOeN, .bankDir, .bankInvert, .bankOpenDrain,
    .cfgPadIn, .cfgPadOut, .cfgPadOeN, .extData, .extLevel, .serial2TerminalReadyOut,
    .ledDriveFirst, .ledDriveSecond, .serial2ClearToSendIn, .irqRequestInputC,
    .kbcPort1Bit7, .edgeIrq);

  always #20 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Samples hready at each edge before the slave's own update lands.
  task automatic ready_edge;
    do
      @(posedge sys_clk);
    while (hreadyout !== 1'b1);
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
    output logic [31:0] rd);
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    ready_edge();
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    ready_edge();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    bus(1'b1, idx, wd, d);
  endtask

  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    bus(1'b0, idx, 8'h00, d);
    chk(nm, d, {24'h0, exp});
  endtask

  task automatic pulses(input int ch, input int pin, input logic v, output int cnt);
    cnt = 0;
    cfgPadIn[pin] <= v;
    repeat (8)
    begin
      @(posedge sys_clk);
      if (edgeIrq[ch] === 1'b1)
        cnt++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 5; i++)
      rchk("config reset", IDX[i], RST[i]);
    rchk("unmapped", 8'h4a, 8'h00);
    chk("led_drive_second drive", {cfgPadOeN[3], cfgPadOut[3]}, 2'b01);
    for (int i = 0; i < 5; i++)
    begin
      wr(IDX[i], 8'hff);
      rchk("config fields", IDX[i], MSK[i]);
      wr(IDX[i], RST[i]);
    end
  endtask

  task automatic t_bank_out;
    bankDir <= 28'h0;
    for (int i = 5; i < 9; i++)
      rchk("bank reset", IDX[i], 8'h00);
    wr(`IDX_BANK1, 8'ha5);
    wr(`IDX_BANK2, 8'h3c);
    wr(`IDX_BANK3, 8'h96);
    wr(`IDX_BANK4, 8'hff);
    tick(3);
    chk("bank drive", bankPadOut, 28'hf963ca5);
    chk("bank enable", bankPadOeN, 28'h0);
    rchk("bank4 stored", `IDX_BANK4, 8'h0f);
    bankInvert <= '1;
    tick(3);
    chk("inverted drive", bankPadOut, 28'h069c35a);
    rchk("stored not inverted", `IDX_BANK2, 8'h3c);
    bankOpenDrain <= '1;
    bankInvert <= 28'h0;
    tick(3);
    chk("drain enable", bankPadOeN, 28'hf963ca5);
  endtask

  task automatic t_bank_in;
    bankDir <= '1;
    bankOpenDrain <= 28'h0;
    bankPadIn <= 28'h7a5c3e1;
    bankInvert <= 28'h00ff00f;
    tick(5);
    chk("input float", bankPadOeN, 28'hfffffff);
    rchk("bank1 in", `IDX_BANK1, 8'hee);
    rchk("bank2 in", `IDX_BANK2, 8'h33);
    rchk("bank3 in", `IDX_BANK3, 8'haa);
    rchk("bank4 in", `IDX_BANK4, 8'h07);
  endtask

  task automatic t_clear;
    bankDir <= 28'h0;
    bankInvert <= 28'h0;
    wr(`IDX_BANK3, 8'hff);
    mainPowerRst <= 1'b1;
    tick(5);
    rchk("main clear", `IDX_BANK3, 8'hf7);
    mainPowerRst <= 1'b0;
    hardRst <= 1'b1;
    tick(5);
    wr(`IDX_BANK3, 8'hff);
    rchk("hard clear", `IDX_BANK3, 8'hf7);
    hardRst <= 1'b0;
    tick(4);
  endtask

  task automatic t_alt;
    wr(`IDX_PIN57, 8'h04);
    serial2TerminalReadyOut <= 1'b1;
    wr(`IDX_PIN60, 8'h04);
    ledDriveFirst <= 1'b1;
    wr(`IDX_PIN56, 8'h05);
    tick(4);
    chk("ready out", {cfgPadOeN[1], cfgPadOut[1]}, 2'b01);
    chk("led_drive_first out", {cfgPadOeN[2], cfgPadOut[2]}, 2'b01);
    chk("cts low", serial2ClearToSendIn, 1'b0);
    wr(`IDX_PIN56, 8'h01);
    tick(3);
    chk("cts idle", serial2ClearToSendIn, 1'b1);
    wr(`IDX_PIN62, 8'h0b);
    tick(5);
    chk("irq inverted", {irqRequestInputC, kbcPort1Bit7}, 2'b11);
    wr(`IDX_PIN62, 8'h05);
    tick(5);
    chk("kbc bit", {irqRequestInputC, kbcPort1Bit7}, 2'b00);
    extData <= 5'h08;
    wr(`IDX_PIN61, 8'h00);
    tick(3);
    chk("gpio out", {cfgPadOeN[3], cfgPadOut[3]}, 2'b01);
    wr(`IDX_PIN61, 8'h82);
    tick(3);
    chk("drain inverted", {cfgPadOeN[3], cfgPadOut[3]}, 2'b00);
    cfgPadIn[3] <= 1'b1;
    wr(`IDX_PIN61, 8'h03);
    tick(5);
    chk("gpio in", {cfgPadOeN[3], extLevel[3]}, 2'b10);
  endtask

  task automatic t_edges;
    int c;
    cfgPadIn[3] <= 1'b0;
    wr(`IDX_PIN60, 8'h09);
    wr(`IDX_PIN61, 8'h09);
    tick(6);
    for (int ch = 0; ch < 2; ch++)
    begin
      pulses(ch, ch + 2, 1'b1, c);
      chk("edge rise", c, 1);
      pulses(ch, ch + 2, 1'b0, c);
      chk("edge fall", c, 1);
    end
    wr(`IDX_PIN60, 8'h01);
    tick(4);
    pulses(0, 2, 1'b1, c);
    chk("gpio no edge", c, 0);
    ce <= 1'b0;
    cfgPadIn[2] <= 1'b0;
    tick(5);
    chk("frozen level", extLevel[2], 1'b1);
    ce <= 1'b1;
    tick(5);
    chk("thawed level", extLevel[2], 1'b0);
  endtask

  task automatic wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs();
    t_bank_out();
    t_bank_in();
    t_clear();
    t_alt();
    t_edges();
    wrap_up();
  end

  // The whole sequence needs well under two thousand cycles.
  initial
  begin
    #200000;
    failures++;
    wrap_up();
  end
endmodule // test_gpio_pin_config_and_data
`default_nettype wire
